// ===== core/bbl_host_port.sv
// Purpose: host-side controller for a boot block flash disk on a memory bus
// Assumes: device pins are asynchronous to core_clk; busy pin pulled up
// Notes:   holds the device in reset, waits for busy release, then serves
//          byte requests into the 8 KB window of a chosen cascade position
//
// Behaviour
// - after download the host reads and runs code from the boot block.
// - device is an SRAM-like 8 KB window placed anywhere free.
// - host drives chip select and strobes with single clean edges.
// - up to four devices share the bus; only position pins differ.
// - positions strapped 00 for one device, then 01, 10, 11 last.
// - BIOS runs the initial_program_loader from the boot block.
// - on PC hosts place the window within 0C8000H to 0EFFFFH.
// - device holds busy low while initialising; host waits for release.
// - first device has both position pins grounded, code 0,0.
`timescale 1ns/1ps
module bbl_host_port
    import bbl_pkg::*;
#(
    parameter int BOOT_WAIT = BOOT_WAIT_CYC
)
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              boot_start,
    input  wire logic [POS_W-1:0]  dev_count_m1,
    input  wire logic              req_valid,
    input  wire bbl_req_s          req,
    output bbl_rsp_s               rsp,
    output logic                   rsp_valid,
    output logic                   ready,
    output logic                   boot_timeout,
    output logic                   host_reset_in_n,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n,
    output logic [WIN_AW-1:0]      addr,
    output logic [POS_W-1:0]       cascade_position,
    output logic [DW-1:0]          dq_out,
    output logic                   dq_oe,
    input  wire logic [DW-1:0]     dq_in,
    input  wire logic              busy_n_in
);

    typedef enum logic [2:0] {
        HP_RESET, HP_WAIT, HP_IDLE, HP_ACCESS, HP_FAIL
    } bbl_hp_e;

    localparam int TW = $clog2(BOOT_WAIT + 1);

    // ==========================================================
    // three-stage synchronisers for the busy pin and data bus
    logic [2:0]     busy_sync;
    logic [DW-1:0]  dq_s1, dq_s2, dq_s3;
    logic           busy_free;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_sync <= 3'h0;
            dq_s1     <= '0;
            dq_s2     <= '0;
            dq_s3     <= '0;
        end else begin
            busy_sync <= {busy_sync[1:0], busy_n_in};
            dq_s1     <= dq_in;
            dq_s2     <= dq_s1;
            dq_s3     <= dq_s2;
        end
    end

    // release counts only once stages two and three agree high
    assign busy_free = busy_sync[1] & busy_sync[2];

    // ==========================================================
    // strobe engine
    logic       sg_start, sg_sample, sg_done, sg_ce_n, sg_oe_n, sg_we_n;
    logic       sg_dq_oe;
    logic [WIN_AW-1:0] sg_addr;
    logic [DW-1:0]     sg_dq;

    bbl_strobe_gen u_strobe (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .start    (sg_start),
        .write    (req.write),
        .addr     (req.addr),
        .wdata    (req.wdata),
        .ce_n     (sg_ce_n),
        .oe_n     (sg_oe_n),
        .we_n     (sg_we_n),
        .addr_out (sg_addr),
        .dq_out   (sg_dq),
        .dq_oe    (sg_dq_oe),
        .sample   (sg_sample),
        .done     (sg_done)
    );

    // ==========================================================
    // boot and access sequencer
    bbl_hp_e            state, next_state;
    logic [TW-1:0]      cnt, next_cnt;
    logic               next_rst_out, next_ready, next_timeout;
    logic               next_rsp_valid, is_write, next_is_write;
    bbl_rsp_s           next_rsp;
    logic [POS_W-1:0]   next_pos;
    logic [DW-1:0]      rd_byte, next_rd_byte;

    // the strobe engine has its own state; start only from idle
    assign sg_start = (state == HP_IDLE) && req_valid
                      && (req.position <= dev_count_m1);

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_rst_out   = host_reset_in_n;
        next_ready     = 1'b0;
        next_timeout   = boot_timeout;
        next_rsp_valid = 1'b0;
        next_rsp       = rsp;
        next_pos       = cascade_position;
        next_is_write  = is_write;
        next_rd_byte   = rd_byte;
        case (state)
            HP_RESET: begin
                // reset pulse meets its least width, then release
                next_rst_out = 1'b0;
                if (cnt >= TW'(RST_PULSE_CYC)) begin
                    next_rst_out = 1'b1;
                    next_cnt     = '0;
                    next_state   = HP_WAIT;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            HP_WAIT: begin
                if (busy_free && cnt >= TW'(4)) begin
                    next_state = HP_IDLE;
                    next_ready = 1'b1;
                end else if (cnt >= TW'(BOOT_WAIT)) begin
                    next_timeout = 1'b1;
                    next_state   = HP_FAIL;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            HP_IDLE: begin
                next_ready = ~sg_start;
                if (req_valid && !sg_start) begin
                    next_rsp_valid = 1'b1;
                    next_rsp       = '{ok: 1'b0, rdata: '0};
                end else if (sg_start) begin
                    next_pos      = req.position;
                    next_is_write = req.write;
                    next_state    = HP_ACCESS;
                end
            end
            HP_ACCESS: begin
                // loader fetch path
                // stage three still holds a byte from before the strobe
                // fell here, so the byte is taken one stage earlier
                if (sg_sample) begin
                    next_rd_byte = dq_s2;
                end
                if (sg_done) begin
                    next_rsp_valid = 1'b1;
                    next_rsp = '{ok: 1'b1,
                                 rdata: is_write ? '0 : rd_byte};
                    next_ready = 1'b1;
                    next_state = HP_IDLE;
                end
            end
            HP_FAIL: begin
                // device never came up; requests are answered as refused
                next_ready = 1'b1;
                if (req_valid) begin
                    next_rsp_valid = 1'b1;
                    next_rsp       = '{ok: 1'b0, rdata: '0};
                end
            end
            default: next_state = HP_RESET;
        endcase
        if (boot_start) begin
            // a fresh boot always restarts the reset pulse
            next_state   = HP_RESET;
            next_cnt     = '0;
            next_rst_out = 1'b0;
            next_ready   = 1'b0;
            next_timeout = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state           <= HP_RESET;
            cnt             <= '0;
            host_reset_in_n <= 1'b0;
            ready           <= 1'b0;
            boot_timeout    <= 1'b0;
            rsp_valid       <= 1'b0;
            rsp             <= '0;
            cascade_position <= '0;
            is_write        <= 1'b0;
            rd_byte         <= '0;
        end else begin
            state           <= next_state;
            cnt             <= next_cnt;
            host_reset_in_n <= next_rst_out;
            ready           <= next_ready;
            boot_timeout    <= next_timeout;
            rsp_valid       <= next_rsp_valid;
            rsp             <= next_rsp;
            cascade_position <= next_pos;
            is_write        <= next_is_write;
            rd_byte         <= next_rd_byte;
        end
    end

    // pin outputs re-registered so each leaves a flip-flop
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ce_n   <= 1'b1;
            oe_n   <= 1'b1;
            we_n   <= 1'b1;
            addr   <= '0;
            dq_out <= '0;
            dq_oe  <= 1'b0;
        end else begin
            ce_n   <= sg_ce_n;
            oe_n   <= sg_oe_n;
            we_n   <= sg_we_n;
            addr   <= sg_addr;
            dq_out <= sg_dq;
            dq_oe  <= sg_dq_oe;
        end
    end

    // ==========================================================
    // checks
    // no access before ready
    property p_quiet_boot;
        @(posedge core_clk) disable iff (!rst_b)
        (state == HP_RESET || state == HP_WAIT) |-> ce_n;
    endproperty
    a_quiet_boot: assert property (p_quiet_boot)
        else $error("chip select during boot");

    property p_wait_busy;
        @(posedge core_clk) disable iff (!rst_b)
        (state == HP_WAIT) ##1 (state == HP_IDLE) |-> $past(busy_free);
    endproperty
    a_wait_busy: assert property (p_wait_busy)
        else $error("left wait with busy low");

    property p_timeout;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(boot_timeout) |-> $past(cnt) >= TW'(BOOT_WAIT);
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout raised early");

    property p_refuse;
        @(posedge core_clk) disable iff (!rst_b)
        (state == HP_IDLE && req_valid && req.position > dev_count_m1
         && !boot_start) |=> rsp_valid && !rsp.ok && ce_n;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("out of range position not refused");

    property p_pos_stable;
        @(posedge core_clk) disable iff (!rst_b)
        (!ce_n && $past(!ce_n)) |-> $stable(cascade_position);
    endproperty
    a_pos_stable: assert property (p_pos_stable)
        else $error("position changed during access");

endmodule

// ===== core/bbl_pkg.sv
// Purpose: shared constants and types for the boot block loader host port
// Assumes: 40 MHz core clock, 8-bit device data bus, 13-bit window address
// Notes:   cycle counts other than SETUP_CYC derive from the times printed beside them
package bbl_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ         = 40;
    localparam int CLK_NS          = 25;
    localparam int BOOT_WAIT_US    = 1000;  // download done within 1 ms
    localparam int BOOT_WAIT_CYC   = BOOT_WAIT_US * CLK_MHZ;
    localparam int RST_PULSE_NS    = 30;    // least reset low width
    localparam int RST_PULSE_CYC   = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_WIDTH_NS     = 50;    // least write strobe width
    localparam int WE_WIDTH_CYC    = (WE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_NS          = 69;    // boot block read access time
    localparam int ACC_CYC         = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_NS          = 17;    // strobe high to next cycle
    localparam int REC_CYC         = (REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC       = 1;     // address and select to strobe

    // ==========================================================
    // window layout
    localparam int WIN_AW          = 13;    // 8 KB window
    localparam int DW              = 8;
    localparam int POS_W           = 2;
    localparam logic [1:0] POS_LAST = 2'h3;
    localparam logic [12:0] BOOT_LO_END  = 13'h07FF;
    localparam logic [12:0] BOOT_HI_BASE = 13'h1800;

    // ==========================================================
    // request and answer carriers
    typedef struct packed {
        logic                 write;
        logic [POS_W-1:0]     position;
        logic [WIN_AW-1:0]    addr;
        logic [DW-1:0]        wdata;
    } bbl_req_s;

    typedef struct packed {
        logic                 ok;       // 0 when refused (position past dev_count_m1, or boot timed out)
        logic [DW-1:0]        rdata;
    } bbl_rsp_s;

endpackage

// ===== core/bbl_strobe_gen.sv
// Purpose: drives one clean strobe cycle on the device pins
// Assumes: start only when idle; timing counts from the package
// Notes:   every pin leaves a flip-flop so each strobe has one edge each way
`timescale 1ns/1ps
module bbl_strobe_gen
    import bbl_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              start,
    input  wire logic              write,
    input  wire logic [WIN_AW-1:0] addr,
    input  wire logic [DW-1:0]     wdata,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n,
    output logic [WIN_AW-1:0]      addr_out,
    output logic [DW-1:0]          dq_out,
    output logic                   dq_oe,
    output logic                   sample,
    output logic                   done
);

    typedef enum logic [1:0] {SG_IDLE, SG_SETUP, SG_STROBE, SG_REC} bbl_sg_e;

    localparam int CNT_W = 4;
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction

    bbl_sg_e            state, next_state;
    logic [CNT_W-1:0]   cnt, next_cnt;
    logic               next_ce_n, next_oe_n, next_we_n, next_dq_oe;
    logic               next_sample, next_done, wr, next_wr;
    logic [WIN_AW-1:0]  next_addr_out;
    logic [DW-1:0]      next_dq_out;

    // ==========================================================
    // strobe sequence: select, strobe low, strobe high, recover
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_ce_n     = ce_n;
        next_oe_n     = oe_n;
        next_we_n     = we_n;
        next_dq_oe    = dq_oe;
        next_addr_out = addr_out;
        next_dq_out   = dq_out;
        next_wr       = wr;
        next_sample   = 1'b0;
        next_done     = 1'b0;
        case (state)
            SG_IDLE: begin
                if (start) begin
                    // address and select lead the strobe by a cycle
                    next_addr_out = addr;
                    next_dq_out   = wdata;
                    next_wr       = write;
                    next_dq_oe    = write;
                    next_ce_n     = 1'b0;
                    next_cnt      = cyc(SETUP_CYC);
                    next_state    = SG_SETUP;
                end
            end
            SG_SETUP: begin
                if (cnt == '0) begin
                    next_oe_n  = wr;
                    next_we_n  = ~wr;
                    next_cnt   = wr ? cyc(WE_WIDTH_CYC) : cyc(ACC_CYC);
                    next_state = SG_STROBE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            SG_STROBE: begin
                if (cnt == '0) begin
                    // read data is taken just before the rising edge
                    next_sample = ~wr;
                    next_oe_n   = 1'b1;
                    next_we_n   = 1'b1;
                    next_cnt    = cyc(REC_CYC);
                    next_state  = SG_REC;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            SG_REC: begin
                // data hold after write edge is one cycle, above zero
                next_ce_n  = 1'b1;
                next_dq_oe = 1'b0;
                if (cnt == '0) begin
                    next_done  = 1'b1;
                    next_state = SG_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: next_state = SG_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= SG_IDLE;
            cnt      <= '0;
            ce_n     <= 1'b1;
            oe_n     <= 1'b1;
            we_n     <= 1'b1;
            dq_oe    <= 1'b0;
            addr_out <= '0;
            dq_out   <= '0;
            wr       <= 1'b0;
            sample   <= 1'b0;
            done     <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            ce_n     <= next_ce_n;
            oe_n     <= next_oe_n;
            we_n     <= next_we_n;
            dq_oe    <= next_dq_oe;
            addr_out <= next_addr_out;
            dq_out   <= next_dq_out;
            wr       <= next_wr;
            sample   <= next_sample;
            done     <= next_done;
        end
    end

    // ==========================================================
    // checks
    // no double strobe
    property p_one_strobe;
        @(posedge core_clk) disable iff (!rst_b)
        !(~oe_n && ~we_n);
    endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("both strobes low together");

    property p_ce_covers;
        @(posedge core_clk) disable iff (!rst_b)
        (~oe_n || ~we_n) |-> ~ce_n;
    endproperty
    a_ce_covers: assert property (p_ce_covers)
        else $error("strobe low without chip select");

    sequence s_we_fall;
        $fell(we_n);
    endsequence
    property p_we_width;
        @(posedge core_clk) disable iff (!rst_b)
        s_we_fall |-> (~we_n && dq_oe) [*2];
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write strobe too short");

endmodule

// ===== testbench/bbl_dev_model.sv
// Purpose: behavioural model of the boot block flash disk on the host bus
// Assumes: strapped positions 0 up to LAST_POS answer, others stay silent
// Notes:   no clock of its own; timing comes from reset and strobe edges
`timescale 1ns/1ps
module bbl_dev_model
    import bbl_pkg::*;
#(
    parameter int          BOOT_NS  = 1500,
    parameter logic [1:0]  LAST_POS = 2'h2
)
(
    input  wire logic              host_reset_in_n,
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [WIN_AW-1:0] addr,
    input  wire logic [POS_W-1:0]  cascade_position,
    input  wire logic [DW-1:0]     dq_out,
    input  wire logic              dq_oe,
    input  wire logic              bad_primary,
    input  wire logic              stuck,
    output logic [DW-1:0]          dq_in,
    output logic                   busy_n_in
);
    // ==========================================================
    // storage
    logic [DW-1:0] boot_blk [0:1023];
    logic [DW-1:0] ram      [0:32767];
    logic [DW-1:0] last_dq;
    logic          busy;
    logic          sel;
    logic          in_boot;

    // open drain busy with pull-up: high once released
    assign busy_n_in = busy ? 1'b0 : 1'b1;
    assign sel       = (cascade_position <= LAST_POS);
    assign in_boot   = (addr <= BOOT_LO_END) || (addr >= BOOT_HI_BASE);

    initial begin
        busy    = 1'b1;
        last_dq = 8'h00;
    end

    // boot download
    // a corrupt primary copy costs a second page fetch of the spare copy
    always @(host_reset_in_n) begin
        if (!host_reset_in_n) begin
            busy = 1'b1;
        end else begin
            #(bad_primary ? 2 * BOOT_NS : BOOT_NS);
            for (int i = 0; i < 1024; i++) begin
                boot_blk[i] = i[7:0] ^ 8'h3C;
            end
            if (host_reset_in_n && !stuck) begin
                busy = 1'b0;
            end
        end
    end

    // write taken on the strobe rising edge
    always @(posedge we_n) begin
        if (ce_n === 1'b0 && sel && !busy && !in_boot) begin
            ram[{cascade_position, addr}] = dq_out;
        end
    end

    // read drive; boot block decodes only addr[9:0], so it aliases
    // no pull on the data lines, so a released bus must not look valid
    always @(*) begin
        if (ce_n === 1'b0 && oe_n === 1'b0 && sel && !busy && !dq_oe) begin
            last_dq = in_boot ? boot_blk[addr[9:0]]
                              : ram[{cascade_position, addr}];
            dq_in   = last_dq;
        end else begin
            dq_in = ~last_dq;
        end
    end
endmodule

// ===== testbench/bbl_host_port_tb.sv
// Purpose: self-checking bench for the boot block loader host port
// Assumes: three devices strapped 0 to 2, shortened boot wait of 200
// Notes:   table of ordinary accesses first, then boot and reset cases
`timescale 1ns/1ps
module bbl_host_port_tb;
    import bbl_pkg::*;

    // ==========================================================
    // signals
    localparam int WAIT = 200;
    typedef struct packed {
        logic        write;
        logic [1:0]  pos;
        logic [12:0] addr;
        logic [7:0]  wdata;
        logic        ok;
        logic [7:0]  rdata;
    } bbl_row_s;
    logic              core_clk;
    logic              rst_b;
    logic              boot_start;
    logic [POS_W-1:0]  dev_count_m1;
    logic              req_valid;
    bbl_req_s          req;
    bbl_rsp_s          rsp;
    bbl_rsp_s          got;
    logic              rsp_valid;
    logic              ready;
    logic              boot_timeout;
    logic              host_reset_in_n;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [WIN_AW-1:0] addr;
    logic [POS_W-1:0]  cascade_position;
    logic [DW-1:0]     dq_out;
    logic              dq_oe;
    logic [DW-1:0]     dq_in;
    logic              busy_n_in;
    logic              bad_primary;
    logic              stuck;
    bbl_row_s          rows [0:8];
    int                miscompares;
    int                check_count;

    bbl_host_port #(.BOOT_WAIT(WAIT)) dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .boot_start(boot_start),
        .dev_count_m1(dev_count_m1), .req_valid(req_valid), .req(req),
        .rsp(rsp), .rsp_valid(rsp_valid), .ready(ready),
        .boot_timeout(boot_timeout), .host_reset_in_n(host_reset_in_n),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .cascade_position(cascade_position), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in), .busy_n_in(busy_n_in));

    bbl_dev_model dev_u (
        .host_reset_in_n(host_reset_in_n), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .addr(addr), .cascade_position(cascade_position),
        .dq_out(dq_out), .dq_oe(dq_oe), .bad_primary(bad_primary),
        .stuck(stuck), .dq_in(dq_in), .busy_n_in(busy_n_in));

    // ==========================================================
    // clock and helpers
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // bounded wait for ready
    task automatic wait_ready(input int limit);
        int n;
        n = 0;
        while (ready !== 1'b1) begin
            n++;
            if (n > limit) begin
                check("ready_timeout", 16'h0000, 16'h0001);
                end_of_test();
            end
            @(negedge core_clk);
        end
    endtask

    // one request held until taken, then wait for the answer pulse
    task automatic access(input logic wr, input logic [1:0] pos,
                          input logic [12:0] a, input logic [7:0] wd);
        int n;
        req_valid = 1'b1;
        req       = '{write: wr, position: pos, addr: a, wdata: wd};
        wait_ready(40);
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1) begin
            n++;
            if (n > 40) begin
                check("answer_timeout", 16'h0000, 16'h0001);
                end_of_test();
            end
            @(negedge core_clk);
        end
        got = rsp;
    endtask

    task automatic reboot();
        boot_start = 1'b1;
        @(negedge core_clk);
        boot_start = 1'b0;
        @(negedge core_clk);
    endtask

    // ready with busy low is only allowed after a boot timeout
    always @(negedge core_clk) begin
        if (rst_b === 1'b1 && ready === 1'b1 && busy_n_in === 1'b0) begin
            check("ready_in_boot", {15'h0, boot_timeout}, 16'h0001);
        end
    end

    // strobes never low together
    always @(negedge core_clk) begin
        if (oe_n === 1'b0 && we_n === 1'b0) begin
            check("strobe_overlap", 16'h0001, 16'h0000);
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        miscompares = 0;
        check_count = 0;
        rst_b       = 1'b0;
        boot_start  = 1'b0;
        dev_count_m1 = 2'h2;
        req_valid   = 1'b0;
        req         = '0;
        bad_primary = 1'b0;
        stuck       = 1'b0;
        // write, pos, addr, wdata, ok, rdata
        rows[0] = '{1'b1, 2'h0, 13'h0800, 8'hA5, 1'b1, 8'h00};
        rows[1] = '{1'b1, 2'h1, 13'h0800, 8'h5A, 1'b1, 8'h00};
        rows[2] = '{1'b0, 2'h0, 13'h0800, 8'h00, 1'b1, 8'hA5};
        rows[3] = '{1'b0, 2'h1, 13'h0800, 8'h00, 1'b1, 8'h5A};
        rows[4] = '{1'b0, 2'h0, 13'h0000, 8'h00, 1'b1, 8'h3C};
        rows[5] = '{1'b0, 2'h0, 13'h1FFF, 8'h00, 1'b1, 8'hC3};
        rows[6] = '{1'b0, 2'h2, 13'h07FF, 8'h00, 1'b1, 8'hC3};
        rows[7] = '{1'b0, 2'h3, 13'h0800, 8'h00, 1'b0, 8'h00};
        rows[8] = '{1'b1, 2'h0, 13'h0000, 8'hEE, 1'b1, 8'h00};
        repeat (16) @(negedge core_clk);
        check("reset_dev", {15'h0, host_reset_in_n}, 16'h0000);
        check("reset_idle", {ce_n, oe_n, we_n, dq_oe, ready}, 16'h001C);
        rst_b = 1'b1;
        wait_ready(WAIT + 60);
        check("boot_ok", {15'h0, boot_timeout}, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            access(rows[i].write, rows[i].pos, rows[i].addr, rows[i].wdata);
            check("rsp_ok", {15'h0, got.ok}, {15'h0, rows[i].ok});
            if (rows[i].ok && !rows[i].write) begin
                check("rdata", {8'h0, got.rdata},
                      {8'h0, rows[i].rdata});
            end
        end
        // boot block stays read only code after a write attempt
        access(1'b0, 2'h0, 13'h0000, 8'h00);
        check("boot_keep", {8'h0, got.rdata}, 16'h003C);
        // corrupt primary copy: spare copy still gives the same code
        bad_primary = 1'b1;
        reboot();
        wait_ready(WAIT + 60);
        check("spare_ok", {15'h0, boot_timeout}, 16'h0000);
        access(1'b0, 2'h1, 13'h0005, 8'h00);
        check("spare_data", {8'h0, got.rdata}, 16'h0039);
        // single device: position 1 is now past the last and refused
        dev_count_m1 = 2'h0;
        access(1'b0, 2'h1, 13'h0800, 8'h00);
        check("one_dev", {15'h0, got.ok}, 16'h0000);
        dev_count_m1 = 2'h2;
        // busy never released: timeout and a position 0 read refused
        stuck = 1'b1;
        reboot();
        wait_ready(WAIT + 60);
        check("timeout", {15'h0, boot_timeout}, 16'h0001);
        access(1'b0, 2'h0, 13'h0800, 8'h00);
        check("refused", {15'h0, got.ok}, 16'h0000);
        // second reset in mid-run, then ram contents still answer
        stuck = 1'b0;
        bad_primary = 1'b0;
        rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        check("rerst", {host_reset_in_n, ready, boot_timeout}, 16'h0000);
        rst_b = 1'b1;
        wait_ready(WAIT + 60);
        access(1'b0, 2'h0, 13'h0800, 8'h00);
        check("after_rst", {7'h0, got.ok, got.rdata}, 16'h01A5);
        end_of_test();
    end
endmodule
